// ### pwm_load_model.sv
`timescale 1ns/1ps
// Motor stage load: measures high time and period of each pin from rising edge to rising edge.
module pwm_load_model (
    input  wire logic        clk,
    input  wire logic [5:0]  pins,
    output logic [5:0][15:0] hi_len,
    output logic [5:0][15:0] per_len
);
    logic [5:0][15:0] cnt;
    logic [5:0][15:0] hc;
    logic [5:0]       prev;
    always @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (pins[i] && !prev[i]) begin
                per_len[i] <= cnt[i];
                hi_len[i]  <= hc[i];
                cnt[i]     <= 16'h1;
                hc[i]      <= 16'h1;
            end else begin
                cnt[i] <= cnt[i] + 16'h1;
                hc[i]  <= hc[i] + {15'h0, pins[i]};
            end
        end
        prev <= pins;
    end
endmodule // pwm_load_model

// ### six_channel_timer_pwm.v
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "six_channel_timer_pwm_consts.vh"

module six_channel_timer_pwm #(
    parameter CHANNELS = 6,
    parameter CW       = 16
) (
    input  wire                clk,
    input  wire                resetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    input  wire [3:0]          pstrb,
    output reg  [31:0]         prdata_q,
    output reg                 pready_q,
    output reg                 pslverr_q,
    input  wire [CHANNELS-1:0] port_latch,
    input  wire                isr_enter,
    output reg  [CHANNELS-1:0] pulse_output_pins_q,
    output reg                 timer_irq_q,
    output reg  [7:0]          timer_vector_q
);

////////////////////////////////////////////////////////////////////////////////

reg rst_meta_q;
reg rst_sync_q;

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rst_meta_q <= 1'b0;
        rst_sync_q <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_sync_q <= rst_meta_q;
    end
end

wire rst_n = rst_sync_q;

////////////////////////////////////////////////////////////////////////////////

// Maps a duty register index to its channel; 7 means no duty register.
function [2:0] duty_chan;
    input [7:0] idx;
    begin
        case (idx)
            `IDX_DUTY0_LOW_BYTE, `IDX_DUTY0_HIGH_BYTE: duty_chan = 3'h0;
            `IDX_DUTY1_LOW_BYTE, `IDX_DUTY1_HIGH_BYTE: duty_chan = 3'h1;
            `IDX_DUTY2_LOW_BYTE, `IDX_DUTY2_HIGH_BYTE: duty_chan = 3'h2;
            `IDX_DUTY3_LOW_BYTE, `IDX_DUTY3_HIGH_BYTE: duty_chan = 3'h3;
            `IDX_DUTY4_LOW_BYTE, `IDX_DUTY4_HIGH_BYTE: duty_chan = 3'h4;
            `IDX_DUTY5_LOW_BYTE, `IDX_DUTY5_HIGH_BYTE: duty_chan = 3'h5;
            default: duty_chan = 3'h7;
        endcase
    end
endfunction

// High byte addresses of the duty pairs are the upper member of each pair.
function duty_is_high;
    input [7:0] idx;
    begin
        case (idx)
            `IDX_DUTY0_HIGH_BYTE, `IDX_DUTY1_HIGH_BYTE, `IDX_DUTY2_HIGH_BYTE,
            `IDX_DUTY3_HIGH_BYTE, `IDX_DUTY4_HIGH_BYTE, `IDX_DUTY5_HIGH_BYTE:
                duty_is_high = 1'b1;
            default: duty_is_high = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg                 run_q;
reg  [2:0]          rate_q;
reg  [CHANNELS-1:0] invert_q;
reg  [CHANNELS-1:0] half_q;
reg  [CHANNELS-1:0] pin_sel_q;
reg  [CW-1:0]       period_q;
reg  [CW-1:0]       duty_q [0:CHANNELS-1];
reg                 global_en_q;
reg                 timer_en_q;
reg                 flag_q;
reg                 lock_q;
reg  [CW-1:0]       count_q;
reg                 phase_q;
reg  [`PRESCALE_BITS-1:0] pre_q;
reg  [CHANNELS-1:0] route_q;
reg                 run_seen_q;

wire [7:0] idx      = paddr[9:2];
wire       setup    = psel & ~penable;
wire       wr_fire  = psel & penable & pready_q & pwrite & pstrb[0];
wire [7:0] wbyte    = pwdata[7:0];
wire [2:0] wchan    = duty_chan(idx);
wire       active   = run_q & ~lock_q;

// A new run request that meets a zero period is held off until run is cleared.
wire run_start  = run_q & ~run_seen_q;
wire lock_now   = run_start & (period_q == `RST_WORD);

// Prescale tick: the low (7 - rate) bits all set, so 111 ticks every cycle.
wire [`PRESCALE_BITS-1:0] pre_mask =
    {`PRESCALE_BITS{1'b1}} >> rate_q;
wire tick = active & ((pre_q & pre_mask) == pre_mask);
wire wrap = tick & (count_q == period_q - 16'h0001);

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
        prdata_q  <= 32'h00000000;
    end else begin
        // One wait-free access: ready rises for the access phase only.
        pready_q  <= setup;
        pslverr_q <= 1'b0;
        prdata_q  <= 32'h00000000;
        if (setup) begin
            if (wchan != 3'h7) begin
                prdata_q[7:0] <= duty_is_high(idx) ? duty_q[wchan][15:8]
                                                   : duty_q[wchan][7:0];
            end else begin
                case (idx)
                    `IDX_TIMER_MODE_CONTROL:
                        prdata_q[7:0] <= {run_q, rate_q, 4'h0};
                    `IDX_COUNTER_LOW_BYTE:
                        prdata_q[7:0] <= count_q[7:0];
                    `IDX_COUNTER_HIGH_BYTE:
                        prdata_q[7:0] <= count_q[15:8];
                    `IDX_PERIOD_LOW_BYTE:
                        prdata_q[7:0] <= period_q[7:0];
                    `IDX_PERIOD_HIGH_BYTE:
                        prdata_q[7:0] <= period_q[15:8];
                    `IDX_OUTPUT_INVERT:
                        prdata_q[7:0] <= {2'h0, invert_q};
                    `IDX_HALF_RATE:
                        prdata_q[7:0] <= {2'h0, half_q};
                    `IDX_PIN_FUNCTION:
                        prdata_q[7:0] <= {2'h0, pin_sel_q};
                    `IDX_IRQ_ENABLE_FIRST:
                        prdata_q[7:0] <= {global_en_q, 7'h00};
                    `IDX_IRQ_ENABLE_SECOND:
                        prdata_q[7:0] <= {6'h00, timer_en_q, 1'b0};
                    `IDX_IRQ_REQUEST_SECOND:
                        prdata_q[7:0] <= {6'h00, flag_q, 1'b0};
                    default:
                        pslverr_q <= 1'b1;
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        run_q       <= 1'b0;
        rate_q      <= 3'h0;
        invert_q    <= {CHANNELS{1'b0}};
        half_q      <= {CHANNELS{1'b0}};
        pin_sel_q   <= {CHANNELS{1'b0}};
        period_q    <= `RST_WORD;
        global_en_q <= 1'b0;
        timer_en_q  <= 1'b0;
    end else if (wr_fire) begin
        case (idx)
            `IDX_TIMER_MODE_CONTROL: begin
                run_q  <= wbyte[`BIT_TIMER_RUN_ENABLE];
                rate_q <= wbyte[`FLD_DIVIDER_HI:`FLD_DIVIDER_LO];
            end
            // A locked timer ignores period writes until run is cleared.
            `IDX_PERIOD_LOW_BYTE:
                if (!lock_q) begin
                    period_q[7:0] <= wbyte;
                end
            `IDX_PERIOD_HIGH_BYTE:
                if (!lock_q) begin
                    period_q[15:8] <= wbyte;
                end
            `IDX_OUTPUT_INVERT:      invert_q    <= wbyte[CHANNELS-1:0];
            `IDX_HALF_RATE:          half_q      <= wbyte[CHANNELS-1:0];
            `IDX_PIN_FUNCTION:       pin_sel_q   <= wbyte[CHANNELS-1:0];
            `IDX_IRQ_ENABLE_FIRST:
                global_en_q <= wbyte[`BIT_GLOBAL_IRQ_ENABLE];
            `IDX_IRQ_ENABLE_SECOND:
                timer_en_q  <= wbyte[`BIT_TIMER_IRQ_ENABLE];
            default: begin
            end
        endcase
    end
end

genvar g;
generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_duty
        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                duty_q[g] <= `RST_WORD;
            end else if (wr_fire && wchan == g) begin
                if (duty_is_high(idx)) begin
                    duty_q[g][15:8] <= wbyte;
                end else begin
                    duty_q[g][7:0] <= wbyte;
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        run_seen_q <= 1'b0;
        lock_q     <= 1'b0;
        pre_q      <= {`PRESCALE_BITS{1'b0}};
        count_q    <= `RST_WORD;
        phase_q    <= 1'b0;
    end else begin
        run_seen_q <= run_q;
        if (!run_q) begin
            lock_q <= 1'b0;
        end else if (lock_now) begin
            lock_q <= 1'b1;
        end
        // Stopping parks the counter at zero so a restart begins a full cycle.
        if (!active || lock_now) begin
            pre_q   <= {`PRESCALE_BITS{1'b0}};
            count_q <= `RST_WORD;
            phase_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 7'h01;
            if (wrap) begin
                count_q <= `RST_WORD;
                phase_q <= ~phase_q;
            end else if (tick) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

// The half-rate position spans two counter cycles, compared against twice
// the duty so the high share matches the full-rate waveform.
wire [CW:0] half_pos = phase_q ? ({1'b0, count_q} + {1'b0, period_q})
                               : {1'b0, count_q};
wire        boundary = active & (count_q == `RST_WORD)
                     & (pre_q & pre_mask) == {`PRESCALE_BITS{1'b0}};

generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
        wire [CW:0] duty2 = {duty_q[g], 1'b0};
        // High from zero until the count meets the duty value.
        wire        full  = count_q < duty_q[g];
        wire        half  = half_pos < duty2;
        wire        wave  = (half_q[g] ? half : full) ^ invert_q[g];

        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                route_q[g]             <= 1'b0;
                pulse_output_pins_q[g] <= 1'b0;
            end else begin
                if (!run_q) begin
                    route_q[g] <= 1'b0;
                end else if (boundary) begin
                    route_q[g] <= pin_sel_q[g];
                end
                if (route_q[g] && active) begin
                    pulse_output_pins_q[g] <= wave;
                end else begin
                    pulse_output_pins_q[g] <= port_latch[g];
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

wire flag_wr  = wr_fire & (idx == `IDX_IRQ_REQUEST_SECOND);
wire flag_set = wrap;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        flag_q         <= 1'b0;
        timer_irq_q    <= 1'b0;
        timer_vector_q <= `TIMER_VECTOR_ADDR;
    end else begin
        // A new overflow wins over a software clear or service entry.
        if (flag_set) begin
            flag_q <= 1'b1;
        end else if (flag_wr) begin
            flag_q <= wbyte[`BIT_TIMER_IRQ_FLAG];
        end else if (isr_enter) begin
            flag_q <= 1'b0;
        end
        timer_irq_q <= flag_q & timer_en_q & global_en_q & ~isr_enter;
        timer_vector_q <= `TIMER_VECTOR_ADDR;
    end
end

endmodule // six_channel_timer_pwm

// ### six_channel_timer_pwm_asserts.sv
`timescale 1ns/1ps
module six_channel_timer_pwm_asserts #(
    parameter CHANNELS = 6,
    parameter CW       = 16
) (
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic [31:0]         prdata_q,
    input wire logic                pready_q,
    input wire logic                pslverr_q,
    input wire logic [CHANNELS-1:0] port_latch,
    input wire logic                isr_enter,
    input wire logic [CHANNELS-1:0] pulse_output_pins_q,
    input wire logic                timer_irq_q,
    input wire logic [7:0]          timer_vector_q
);
    // Shadows of the enables, kept from the bus, so gating can be judged at the ports.
    logic [1:0] up_q;
    logic       run_q;
    logic       en1_q;
    logic       en2_q;
    logic       map_q;
    wire        wr_acc = psel && penable && pready_q && pwrite && pstrb[0];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            up_q  <= 2'd0;
            run_q <= 1'b0;
            en1_q <= 1'b0;
            en2_q <= 1'b0;
        end else begin
            if (up_q != 2'd3) up_q <= up_q + 2'd1;
            if (wr_acc && paddr[9:2] == 8'ha1) run_q <= pwdata[7];
            if (wr_acc && paddr[9:2] == 8'ha8) en1_q <= pwdata[7];
            if (wr_acc && paddr[9:2] == 8'h9a) en2_q <= pwdata[1];
        end
    end
    always_ff @(posedge clk) begin
        map_q <= paddr[9:2] inside {8'h9a, [8'ha1:8'ha8], [8'hab:8'hae], [8'hb1:8'hb6],
                                    [8'hbc:8'hbf]};
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    pready_answer_a: assert property (psel && !penable |=> pready_q)
        else $error("ready missing after setup");
    ready_cause_a: assert property (pready_q |-> psel && penable && $past(psel && !penable))
        else $error("ready without request");
    vector_fixed_a: assert property (timer_vector_q == 8'heb)
        else $error("vector wrong");
    err_zero_a: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0)
        else $error("error response malformed");
    err_map_a: assert property (pready_q |-> pslverr_q == !map_q)
        else $error("error flag does not match map");
    irq_gated_a: assert property (timer_irq_q |-> $past(en1_q && en2_q))
        else $error("irq while disabled");
    isr_clear_a: assert property (isr_enter |=> !timer_irq_q)
        else $error("irq kept after service entry");
    pins_port_a: assert property (up_q == 2'd3 && !run_q |=>
        pulse_output_pins_q == $past(port_latch))
        else $error("stopped pins not port state");
endmodule // six_channel_timer_pwm_asserts

bind six_channel_timer_pwm six_channel_timer_pwm_asserts #(.CHANNELS(CHANNELS), .CW(CW)) chk (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .port_latch(port_latch), .isr_enter(isr_enter),
    .pulse_output_pins_q(pulse_output_pins_q), .timer_irq_q(timer_irq_q),
    .timer_vector_q(timer_vector_q));

// ### six_channel_timer_pwm_consts.vh
`ifndef SIX_CHANNEL_TIMER_PWM_CONSTS_VH
`define SIX_CHANNEL_TIMER_PWM_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_IRQ_ENABLE_SECOND   8'h9a
`define IDX_TIMER_MODE_CONTROL  8'ha1
`define IDX_COUNTER_LOW_BYTE    8'ha2
`define IDX_COUNTER_HIGH_BYTE   8'ha3
`define IDX_PERIOD_LOW_BYTE     8'ha4
`define IDX_PERIOD_HIGH_BYTE    8'ha5
`define IDX_DUTY0_LOW_BYTE      8'ha6
`define IDX_DUTY0_HIGH_BYTE     8'ha7
`define IDX_IRQ_ENABLE_FIRST    8'ha8
`define IDX_DUTY1_LOW_BYTE      8'hab
`define IDX_DUTY1_HIGH_BYTE     8'hac
`define IDX_DUTY2_LOW_BYTE      8'had
`define IDX_DUTY2_HIGH_BYTE     8'hae
`define IDX_DUTY3_LOW_BYTE      8'hb1
`define IDX_DUTY3_HIGH_BYTE     8'hb2
`define IDX_DUTY4_LOW_BYTE      8'hb3
`define IDX_DUTY4_HIGH_BYTE     8'hb4
`define IDX_DUTY5_LOW_BYTE      8'hb5
`define IDX_DUTY5_HIGH_BYTE     8'hb6
`define IDX_OUTPUT_INVERT       8'hbc
`define IDX_HALF_RATE           8'hbd
`define IDX_PIN_FUNCTION        8'hbe
`define IDX_IRQ_REQUEST_SECOND  8'hbf

// Field positions.
`define BIT_TIMER_RUN_ENABLE    7
`define FLD_DIVIDER_HI          6
`define FLD_DIVIDER_LO          4
`define BIT_GLOBAL_IRQ_ENABLE   7
`define BIT_TIMER_IRQ_ENABLE    1
`define BIT_TIMER_IRQ_FLAG      1

// Reset values and fixed codes.
`define RST_BYTE                8'h00
`define RST_WORD                16'h0000
`define TIMER_VECTOR_ADDR       8'heb
`define DIV_UNDIVIDED           3'h7
`define PRESCALE_BITS           7

`endif

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic             clk, resetn, psel, penable, pwrite, isr_enter, er;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic [3:0]       pstrb;
    logic [5:0]       port_latch, inv, half;
    wire  [31:0]      prdata_q;
    wire              pready_q, pslverr_q, timer_irq_q;
    wire  [5:0]       pins;
    wire  [7:0]       timer_vector_q;
    wire  [5:0][15:0] hi_len, per_len;
    int               n_errors = 0, num_checks = 0, n;
    logic [31:0]      seed = 32'hb8acac89;
    logic [7:0]       rd, v;
    logic [15:0]      per, hl;
    logic [15:0]      duty [6];
    logic [2:0]       rate;
    logic [7:0]       ridx [19] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hab, 8'hac,
        8'had, 8'hae, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hbc, 8'hbd, 8'hbe};
    logic [7:0]       dl [6] = '{8'ha6, 8'hab, 8'had, 8'hb1, 8'hb3, 8'hb5};

    six_channel_timer_pwm dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .port_latch(port_latch),
        .isr_enter(isr_enter), .pulse_output_pins_q(pins), .timer_irq_q(timer_irq_q),
        .timer_vector_q(timer_vector_q));
    pwm_load_model load (.clk(clk), .pins(pins), .hi_len(hi_len), .per_len(per_len));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // One count step lasts 2^(7-rate) clocks; half rate doubles both lengths.
    function logic [15:0] exp_len(input logic [15:0] l, input logic h, input logic [2:0] r);
        return l << (3'd7 - r + {2'b0, h});
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // The first edge is spent so that back-to-back calls never drive psel twice at once.
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready_q !== 1'b1);
        chk(pready_q, 1'b1);
        rd = prdata_q[7:0];
        er = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        {resetn, psel, penable, pwrite, isr_enter} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        port_latch = 6'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ridx[i]) begin
            apb(1'b0, ridx[i], 8'h0);
            chk(rd, 8'h0);
        end
        for (int i = 2; i < 19; i++) begin
            v = rnd();
            if (ridx[i] > 8'hbb) v = v & 8'h3f;
            apb(1'b1, ridx[i], v);
            apb(1'b0, ridx[i], 8'h0);
            chk(rd, v);
        end
        apb(1'b0, 8'h90, 8'h0);
        chk({er, rd}, 9'h100);
        apb(1'b1, 8'ha2, 8'h5a);
        apb(1'b0, 8'ha2, 8'h0);
        chk(rd, 8'h0);
        apb(1'b1, 8'ha1, 8'h7f);
        apb(1'b0, 8'ha1, 8'h0);
        chk(rd, 8'h70);
        apb(1'b1, 8'ha4, 8'h0);
        apb(1'b1, 8'ha5, 8'h0);
        apb(1'b1, 8'ha1, 8'hf0);
        repeat (20) @(posedge clk);
        apb(1'b1, 8'ha4, 8'h05);
        apb(1'b0, 8'ha4, 8'h0);
        chk(rd, 8'h0);
        apb(1'b0, 8'ha2, 8'h0);
        chk(rd, 8'h0);
        apb(1'b1, 8'ha1, 8'h0);
        repeat (4) begin
            per = 16'd4 + 16'(rnd() % 12);
            rate = 3'd5 + 3'(rnd() % 3);
            inv = 6'(rnd());
            half = 6'(rnd());
            apb(1'b1, 8'ha4, per[7:0]);
            apb(1'b1, 8'ha5, 8'h0);
            for (int c = 0; c < 6; c++) begin
                duty[c] = 16'd1 + 16'(rnd() % (per - 16'd1));
                apb(1'b1, dl[c], duty[c][7:0]);
                apb(1'b1, dl[c] + 8'h1, duty[c][15:8]);
            end
            apb(1'b1, 8'hbc, {2'b0, inv});
            apb(1'b1, 8'hbd, {2'b0, half});
            apb(1'b1, 8'hbe, 8'h3f);
            port_latch <= 6'(rnd());
            apb(1'b1, 8'ha1, {1'b1, rate, 4'h0});
            repeat (500) @(posedge clk);
            for (int c = 0; c < 6; c++) begin
                chk(per_len[c], exp_len(per, half[c], rate));
                hl = inv[c] ? per - duty[c] : duty[c];
                chk(hi_len[c], exp_len(hl, half[c], rate));
            end
            apb(1'b1, 8'ha1, 8'h0);
            repeat (2) @(posedge clk);
            chk(pins, port_latch);
        end
        // A fresh start at a slow rate: the count shows 3 after three full steps.
        rate = 3'(rnd() % 5);
        apb(1'b1, 8'ha1, {1'b1, rate, 4'h0});
        repeat ((3 << (7 - rate)) - 1) @(posedge clk);
        apb(1'b0, 8'ha2, 8'h0);
        chk(rd, 8'h03);
        apb(1'b1, 8'ha1, 8'hf0);
        apb(1'b1, 8'h9a, 8'h02);
        apb(1'b1, 8'ha8, 8'h80);
        n = 0;
        while (timer_irq_q !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(timer_irq_q, 1'b1);
        chk(timer_vector_q, 8'heb);
        apb(1'b0, 8'hbf, 8'h0);
        chk(rd, 8'h02);
        // Stop first, so no new overflow can hide the clear by service entry.
        apb(1'b1, 8'ha1, 8'h0);
        isr_enter <= 1'b1;
        @(posedge clk);
        isr_enter <= 1'b0;
        apb(1'b0, 8'hbf, 8'h0);
        chk(rd, 8'h00);
        apb(1'b1, 8'hbf, 8'h02);
        repeat (2) @(posedge clk);
        chk(timer_irq_q, 1'b1);
        apb(1'b1, 8'ha8, 8'h0);
        repeat (2) @(posedge clk);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            if (timer_irq_q !== 1'b0) n++;
        end
        chk(n, 0);
        apb(1'b1, 8'h9a, 8'h00);
        apb(1'b1, 8'ha8, 8'h80);
        n = 0;
        repeat (50) begin
            @(posedge clk);
            if (timer_irq_q !== 1'b0) n++;
        end
        chk(n, 0);
        summarize();
    end
endmodule // tb_top
